// ### hdl/can_msg_pkg.sv
// Constants and types for the CAN message receive and transmit block
// Summary of operation
// RL1 - Receiver keeps only messages with the configured identifier on its interface.
// RL2 - A matching message presents its payload as eight bytes.
// RL3 - New-data flag is 1 in steps with new matching data, else 0.
// RL4 - Receive data stays eight bytes wide whatever the message length.
// RL5 - Both sides handle 11-bit base and 29-bit extended identifiers.
// RL6 - Filter format is base, extended, or auto: base below 2047.
// RL7 - Identifier comes from a register or a run-time input, per source bit.
// RL8 - Transmit length equals the byte width setting, one to eight.
// RL9 - Transmitter runs regular (periodic) or triggered.
// RL10 - Trigger sends on rising, falling or either change of zero state.
// RL11 - Regular mode repeats with the configured period.
// RL12 - Every sent message carries the transmit identifier.
// RL13 - Trigger starts as zero; no qualifying change sends nothing.
package can_msg_pkg;
  localparam int ID_W = 29;
  localparam int BASE_ID_W = 11;
  localparam int DATA_BYTES = 8;
  localparam int DATA_W = 64;
  localparam int LEN_W = 4;
  localparam int TRIG_W = 8;
  localparam int PERIOD_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [ID_W-1:0] AUTO_BASE_LIMIT = 29'h00007ff;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_TIME_NS = 1000;
  localparam int STEP_CYC = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int STEP_CNT_W = $clog2(STEP_CYC);
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RX_ID = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TX_ID = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TX_PERIOD = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_RX_LO = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_RX_HI = 8'h20;
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_TX_EN = 1;
  localparam int CTRL_RX_ID_SRC = 2;
  localparam int CTRL_TX_ID_SRC = 3;
  localparam int CTRL_RX_FMT = 4;
  localparam int CTRL_TX_FMT = 6;
  localparam int CTRL_TRIG_MODE = 8;
  localparam int CTRL_TRIG_TYPE = 9;
  localparam int CTRL_TX_LEN = 11;
  localparam int CTRL_RX_IF = 14;
  localparam int CTRL_TX_IF = 15;
  localparam int CTRL_W = 16;
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h3820;
  localparam logic [ID_W-1:0] ID_RST = 29'h0000000;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0001;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_DROP = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam int STAT_RX_NEW = 0;
  localparam int STAT_TX_PEND = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {FMT_BASE, FMT_EXT, FMT_AUTO} fmt_t;
  typedef enum logic [1:0] {TRIG_RISE, TRIG_FALL, TRIG_EITHER} trig_t;

  function automatic logic use_ext(input logic [1:0] fmt, input logic [ID_W-1:0] id);
    case (fmt)
      FMT_BASE: use_ext = 1'b0;
      FMT_EXT: use_ext = 1'b1;
      default: use_ext = (id >= AUTO_BASE_LIMIT);
    endcase
  endfunction
endpackage

// ### hdl/can_tx_sched.sv
// Step scheduler that decides when a message is sent
`timescale 1ns/1ps
module can_tx_sched
  import can_msg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic step_tick,
  input wire logic enable,
  input wire logic trig_mode,
  input wire logic [1:0] trig_type,
  input wire logic trig_level,
  input wire logic [can_msg_pkg::PERIOD_W-1:0] period,
  output logic fire
);
  import can_msg_pkg::*;
  logic trig_prev_q;
  logic trig_prev_d;
  logic [PERIOD_W-1:0] cnt_q;
  logic [PERIOD_W-1:0] cnt_d;
  logic [PERIOD_W-1:0] last_cnt;
  logic rise;
  logic fall;
  logic edge_hit;
  logic cnt_done;

  assign rise = trig_level & ~trig_prev_q;
  assign fall = ~trig_level & trig_prev_q;
  assign edge_hit = (trig_type == TRIG_RISE) ? rise :  // RL10
                    (trig_type == TRIG_FALL) ? fall : (rise | fall);
  // Zero period would wrap to the longest count; treat it as one step
  assign last_cnt = (period == '0) ? '0 : period - 16'h0001;
  assign cnt_done = (cnt_q >= last_cnt);  // RL11
  assign fire = step_tick & enable & (trig_mode ? edge_hit : cnt_done);  // RL9 RL13
  assign trig_prev_d = step_tick ? trig_level : trig_prev_q;
  assign cnt_d = (!enable || trig_mode) ? '0 :
                 !step_tick ? cnt_q :
                 cnt_done ? '0 : cnt_q + 16'h0001;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      trig_prev_q <= 1'b0;  // RL13
      cnt_q <= '0;
    end
    else
    begin
      trig_prev_q <= trig_prev_d;
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_trig_rise_fires: assert property (  // RL10
    step_tick && enable && trig_mode && trig_type == TRIG_RISE
    && trig_level && !trig_prev_q |-> fire)
    else $error("rising trigger did not send");
  chk_trig_quiet: assert property (  // RL13
    trig_mode && (trig_level == trig_prev_q) |-> !fire)
    else $error("send without trigger change");
  cover_trig_fire: cover property (trig_mode && fire);
endmodule

// ### hdl/can_msg_blocks.sv
// CAN message receive and transmit block with AXI4-Lite registers
`timescale 1ns/1ps
module can_msg_blocks
  import can_msg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [can_msg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [can_msg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic step_tick,
  input wire logic rx_msg_valid,
  input wire logic rx_msg_if,
  input wire logic [can_msg_pkg::ID_W-1:0] rx_msg_id,
  input wire logic rx_msg_ext,
  input wire logic [can_msg_pkg::LEN_W-1:0] rx_msg_len,
  input wire logic [can_msg_pkg::DATA_W-1:0] rx_msg_data,
  output logic tx_msg_valid,
  input wire logic tx_msg_ready,
  output logic tx_msg_if,
  output logic [can_msg_pkg::ID_W-1:0] tx_msg_id,
  output logic tx_msg_ext,
  output logic [can_msg_pkg::LEN_W-1:0] tx_msg_len,
  output logic [can_msg_pkg::DATA_W-1:0] tx_msg_data,
  input wire logic [can_msg_pkg::ID_W-1:0] rx_id_in,
  output logic [can_msg_pkg::DATA_W-1:0] rx_data,
  output logic rx_new,
  input wire logic [can_msg_pkg::ID_W-1:0] tx_id_in,
  input wire logic [can_msg_pkg::DATA_W-1:0] tx_data_in,
  input wire logic [can_msg_pkg::TRIG_W-1:0] tx_trigger
);
  import can_msg_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = nw[8*i +: 8];
    merge = res;
  endfunction

  // Simulation step generator
  logic [STEP_CNT_W-1:0] step_cnt_q;
  logic [STEP_CNT_W-1:0] step_cnt_d;
  assign step_tick = (step_cnt_q == STEP_CNT_W'(STEP_CYC - 1));
  assign step_cnt_d = step_tick ? '0 : step_cnt_q + STEP_CNT_W'(1);

  // Registers
  logic [CTRL_W-1:0] ctrl_q;
  logic [ID_W-1:0] rx_id_q;
  logic [ID_W-1:0] tx_id_q;
  logic [PERIOD_W-1:0] period_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // AXI4-Lite write side: address and data latch independently
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  logic wr_hit;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_rx_id;
  logic [31:0] wr_tx_id;
  logic [31:0] wr_period;
  logic [31:0] wr_stat;
  logic [31:0] wr_mask;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_hit = (aw_addr_q == OFF_CTRL) || (aw_addr_q == OFF_RX_ID)
                || (aw_addr_q == OFF_TX_ID) || (aw_addr_q == OFF_TX_PERIOD)
                || (aw_addr_q == OFF_IRQ_STAT) || (aw_addr_q == OFF_IRQ_MASK)
                || (aw_addr_q == OFF_STATUS) || (aw_addr_q == OFF_RX_LO)
                || (aw_addr_q == OFF_RX_HI);
  assign wr_ctrl = merge({16'h0000, ctrl_q}, wdata_q, wstrb_q);
  assign wr_rx_id = merge({3'h0, rx_id_q}, wdata_q, wstrb_q);
  assign wr_tx_id = merge({3'h0, tx_id_q}, wdata_q, wstrb_q);
  assign wr_period = merge({16'h0000, period_q}, wdata_q, wstrb_q);
  assign wr_stat = merge(32'h00000000, wdata_q, wstrb_q);
  assign wr_mask = merge({29'h00000000, irq_mask_q}, wdata_q, wstrb_q);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read side answers in the cycle after the address is taken
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [31:0] status_word;
  logic tx_valid_q;
  logic rx_new_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign status_word = {30'h00000000, tx_valid_q, rx_new_q};
  assign rd_hit = wr_hit_rd(s_axi_araddr);
  assign rd_mux = (s_axi_araddr == OFF_CTRL) ? {16'h0000, ctrl_q} :
                  (s_axi_araddr == OFF_RX_ID) ? {3'h0, rx_id_q} :
                  (s_axi_araddr == OFF_TX_ID) ? {3'h0, tx_id_q} :
                  (s_axi_araddr == OFF_TX_PERIOD) ? {16'h0000, period_q} :
                  (s_axi_araddr == OFF_STATUS) ? status_word :
                  (s_axi_araddr == OFF_IRQ_STAT) ? {29'h00000000, irq_stat_q} :
                  (s_axi_araddr == OFF_IRQ_MASK) ? {29'h00000000, irq_mask_q} :
                  (s_axi_araddr == OFF_RX_LO) ? rx_data[31:0] :
                  (s_axi_araddr == OFF_RX_HI) ? rx_data[63:32] : 32'h00000000;

  function automatic logic wr_hit_rd(input logic [ADDR_W-1:0] a);
    wr_hit_rd = (a == OFF_CTRL) || (a == OFF_RX_ID) || (a == OFF_TX_ID)
              || (a == OFF_TX_PERIOD) || (a == OFF_STATUS) || (a == OFF_IRQ_STAT)
              || (a == OFF_IRQ_MASK) || (a == OFF_RX_LO) || (a == OFF_RX_HI);
  endfunction

  // Receive path
  logic [ID_W-1:0] rx_cfg_id;
  logic rx_want_ext;
  logic [ID_W-1:0] rx_cmp_id;
  logic rx_match;
  logic [DATA_W-1:0] rx_fill;
  logic rx_pend_q;
  logic rx_pend_d;
  logic [DATA_W-1:0] rx_buf_q;
  logic [DATA_W-1:0] rx_data_q;

  assign rx_cfg_id = ctrl_q[CTRL_RX_ID_SRC] ? rx_id_in : rx_id_q;  // RL7
  assign rx_want_ext = use_ext(ctrl_q[CTRL_RX_FMT +: 2], rx_cfg_id);  // RL6
  // Base frames carry only the low 11 identifier bits
  assign rx_cmp_id = rx_msg_ext ? rx_msg_id
                   : {{(ID_W-BASE_ID_W){1'b0}}, rx_msg_id[BASE_ID_W-1:0]};  // RL5
  assign rx_match = rx_msg_valid && ctrl_q[CTRL_RX_EN]
                 && (rx_msg_if == ctrl_q[CTRL_RX_IF])
                 && (rx_msg_ext == rx_want_ext)
                 && (rx_cmp_id == rx_cfg_id);  // RL1
  // Hardware set wins over the step-boundary clear
  assign rx_pend_d = rx_match | (rx_pend_q & ~step_tick);  // RL3
  assign rx_data = rx_data_q;
  assign rx_new = rx_new_q;

  // Transmit path
  logic fire;
  logic [ID_W-1:0] tx_cfg_id;
  logic tx_use_ext;
  logic [LEN_W-1:0] tx_len_cfg;
  logic [DATA_W-1:0] tx_fill;
  logic [ID_W-1:0] tx_id_q2;
  logic tx_ext_q;
  logic tx_if_q;
  logic [LEN_W-1:0] tx_len_q;
  logic [DATA_W-1:0] tx_data_q;
  logic tx_load;
  logic tx_drop;

  assign tx_len_cfg = {1'b0, ctrl_q[CTRL_TX_LEN +: 3]} + 4'h1;  // RL8
  assign tx_cfg_id = ctrl_q[CTRL_TX_ID_SRC] ? tx_id_in : tx_id_q;  // RL7
  assign tx_use_ext = use_ext(ctrl_q[CTRL_TX_FMT +: 2], tx_cfg_id);  // RL5
  // A send while the last one waits would break the held payload, so it drops
  assign tx_load = fire && !tx_valid_q;
  assign tx_drop = fire && tx_valid_q;

  genvar gi;
  generate
    for (gi = 0; gi < DATA_BYTES; gi++)
    begin : g_byte
      assign rx_fill[8*gi +: 8] = (LEN_W'(gi) < rx_msg_len) ? rx_msg_data[8*gi +: 8]
                                : 8'h00;  // RL4
      assign tx_fill[8*gi +: 8] = (LEN_W'(gi) < tx_len_cfg) ? tx_data_in[8*gi +: 8]
                                : 8'h00;  // RL8
    end
  endgenerate

  can_tx_sched u_sched (
    .sys_clk(sys_clk),
    .rst(rst),
    .step_tick(step_tick),
    .enable(ctrl_q[CTRL_TX_EN]),
    .trig_mode(ctrl_q[CTRL_TRIG_MODE]),
    .trig_type(ctrl_q[CTRL_TRIG_TYPE +: 2]),
    .trig_level(tx_trigger != '0),
    .period(period_q),
    .fire(fire)
  );

  assign tx_msg_valid = tx_valid_q;
  assign tx_msg_id = tx_id_q2;
  assign tx_msg_ext = tx_ext_q;
  assign tx_msg_if = tx_if_q;
  assign tx_msg_len = tx_len_q;
  assign tx_msg_data = tx_data_q;

  // Interrupts
  assign irq_set = {tx_drop, tx_valid_q & tx_msg_ready, rx_match};
  assign irq_clr = (do_write && aw_addr_q == OFF_IRQ_STAT) ? wr_stat[IRQ_W-1:0] : '0;
  assign irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);
  assign irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      step_cnt_q <= '0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      step_cnt_q <= step_cnt_d;
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_full_q <= 1'b0;
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (do_write)
        w_full_q <= 1'b0;
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      if (s_axi_arvalid && !rvalid_q)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RST;
      rx_id_q <= ID_RST;
      tx_id_q <= ID_RST;
      period_q <= PERIOD_RST;
      irq_mask_q <= IRQ_MASK_RST;
      irq_stat_q <= '0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      if (do_write && aw_addr_q == OFF_CTRL)
        ctrl_q <= wr_ctrl[CTRL_W-1:0];
      if (do_write && aw_addr_q == OFF_RX_ID)
        rx_id_q <= wr_rx_id[ID_W-1:0];
      if (do_write && aw_addr_q == OFF_TX_ID)
        tx_id_q <= wr_tx_id[ID_W-1:0];
      if (do_write && aw_addr_q == OFF_TX_PERIOD)
        period_q <= wr_period[PERIOD_W-1:0];
      if (do_write && aw_addr_q == OFF_IRQ_MASK)
        irq_mask_q <= wr_mask[IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_pend_q <= 1'b0;
      rx_buf_q <= '0;
      rx_data_q <= '0;
      rx_new_q <= 1'b0;
    end
    else
    begin
      rx_pend_q <= rx_pend_d;
      if (rx_match)
        rx_buf_q <= rx_fill;  // RL2
      if (step_tick)
      begin
        rx_new_q <= rx_pend_q;  // RL3
        if (rx_pend_q)
          rx_data_q <= rx_buf_q;  // RL2
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_valid_q <= 1'b0;
      tx_id_q2 <= '0;
      tx_ext_q <= 1'b0;
      tx_if_q <= 1'b0;
      tx_len_q <= '0;
      tx_data_q <= '0;
    end
    else if (tx_load)
    begin
      tx_valid_q <= 1'b1;
      tx_id_q2 <= tx_use_ext ? tx_cfg_id
                : {{(ID_W-BASE_ID_W){1'b0}}, tx_cfg_id[BASE_ID_W-1:0]};  // RL12
      tx_ext_q <= tx_use_ext;
      tx_if_q <= ctrl_q[CTRL_TX_IF];
      tx_len_q <= tx_len_cfg;
      tx_data_q <= tx_fill;
    end
    else if (tx_msg_ready)
      tx_valid_q <= 1'b0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_rx_new_steady: assert property (!step_tick |=> $stable(rx_new))  // RL3
    else $error("new-data flag changed inside a step");
  chk_rx_new_cause: assert property (step_tick && rx_pend_q |=> rx_new)  // RL3
    else $error("new-data flag missing after match");
  chk_rx_no_match: assert property (step_tick && !rx_pend_q |=> !rx_new)  // RL1
    else $error("new-data flag without a match");
  chk_rx_data_held: assert property (!step_tick |=> $stable(rx_data))  // RL2
    else $error("receive data moved inside a step");
  chk_tx_len_range: assert property (
    tx_msg_valid |-> tx_msg_len >= 4'h1 && tx_msg_len <= 4'h8)  // RL8
    else $error("transmit length outside one to eight");
  chk_tx_hold: assert property (tx_msg_valid && !tx_msg_ready |=>  // RL12
    tx_msg_valid && $stable(tx_msg_id) && $stable(tx_msg_data))
    else $error("transmit payload not held");
  chk_tx_on_step: assert property ($rose(tx_msg_valid) |-> $past(step_tick))  // RL11
    else $error("send not aligned to a step");
  chk_tx_base_id: assert property (
    tx_msg_valid && !tx_msg_ext |-> tx_msg_id[ID_W-1:BASE_ID_W] == '0)  // RL5
    else $error("base frame with wide identifier");
  cover_rx_new: cover property (rx_new ##1 !rx_new);
  cover_tx_taken: cover property (tx_msg_valid && tx_msg_ready);
  cover_tx_drop: cover property (tx_drop);
endmodule

// ### verification/can_bus_node.sv
// Behavioural model of the other nodes on the shared CAN bus
`timescale 1ns/1ps
module can_bus_node
  import can_msg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  output logic rx_msg_valid,
  output logic rx_msg_if,
  output logic [can_msg_pkg::ID_W-1:0] rx_msg_id,
  output logic rx_msg_ext,
  output logic [can_msg_pkg::LEN_W-1:0] rx_msg_len,
  output logic [can_msg_pkg::DATA_W-1:0] rx_msg_data,
  input wire logic tx_msg_valid,
  output logic tx_msg_ready,
  input wire logic tx_msg_if,
  input wire logic [can_msg_pkg::ID_W-1:0] tx_msg_id,
  input wire logic tx_msg_ext,
  input wire logic [can_msg_pkg::LEN_W-1:0] tx_msg_len,
  input wire logic [can_msg_pkg::DATA_W-1:0] tx_msg_data
);
  typedef struct packed {logic [31:0] cyc; logic mif; logic ext; logic [3:0] len;
    logic [ID_W-1:0] id; logic [DATA_W-1:0] data;} tx_rec_t;
  tx_rec_t got_q[$];
  int stall;
  int wait_cnt;
  logic [31:0] cyc;
  initial
  begin
    stall = 0;
    {tx_msg_ready, rx_msg_valid, rx_msg_if, rx_msg_id, rx_msg_ext, rx_msg_len, rx_msg_data} = '0;
  end
  // Idle fields show the inverse of the last frame, never a stale copy
  task automatic send(input logic mif, input logic [ID_W-1:0] id, input logic ext,
    input logic [LEN_W-1:0] len, input logic [DATA_W-1:0] data);
    @(posedge sys_clk);
    rx_msg_valid <= 1'b1;
    rx_msg_if <= mif;
    rx_msg_id <= id;
    rx_msg_ext <= ext;
    rx_msg_len <= len;
    rx_msg_data <= data;
    @(posedge sys_clk);
    rx_msg_valid <= 1'b0;
    rx_msg_if <= ~mif;
    rx_msg_id <= ~id;
    rx_msg_ext <= ~ext;
    rx_msg_len <= ~len;
    rx_msg_data <= ~data;
  endtask
  // Ready after a set stall, so slow arbitration on the bus is modelled
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_msg_ready <= 1'b0;
      wait_cnt <= 0;
      cyc <= '0;
    end
    else
    begin
      cyc <= cyc + 1;
      if (tx_msg_valid && tx_msg_ready)
      begin
        got_q.push_back({cyc, tx_msg_if, tx_msg_ext, tx_msg_len, tx_msg_id, tx_msg_data});
        tx_msg_ready <= 1'b0;
        wait_cnt <= 0;
      end
      else if (tx_msg_valid)
      begin
        if (wait_cnt >= stall)
          tx_msg_ready <= 1'b1;
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule

// ### verification/can_message_rx_tx_blocks_tb.sv
// Self-checking bench for the CAN message receive and transmit block
`timescale 1ns/1ps
module can_message_rx_tx_blocks_tb;
  import can_msg_pkg::*;
  logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, step_tick;
  logic rx_msg_valid, rx_msg_if, rx_msg_ext, tx_msg_valid, tx_msg_ready, tx_msg_if, tx_msg_ext;
  logic rx_new;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [ID_W-1:0] rx_msg_id, tx_msg_id, rx_id_in, tx_id_in;
  logic [LEN_W-1:0] rx_msg_len, tx_msg_len;
  logic [DATA_W-1:0] rx_msg_data, tx_msg_data, rx_data, tx_data_in;
  logic [TRIG_W-1:0] tx_trigger;
  int errors, tests_run, cycles, seed;
  can_msg_blocks i_can_msg_blocks (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .step_tick, .rx_msg_valid, .rx_msg_if,
    .rx_msg_id, .rx_msg_ext, .rx_msg_len, .rx_msg_data, .tx_msg_valid, .tx_msg_ready,
    .tx_msg_if, .tx_msg_id, .tx_msg_ext, .tx_msg_len, .tx_msg_data, .rx_id_in, .rx_data,
    .rx_new, .tx_id_in, .tx_data_in, .tx_trigger);
  can_bus_node i_can_bus_node (.sys_clk, .rst, .rx_msg_valid, .rx_msg_if, .rx_msg_id,
    .rx_msg_ext, .rx_msg_len, .rx_msg_data, .tx_msg_valid, .tx_msg_ready, .tx_msg_if,
    .tx_msg_id, .tx_msg_ext, .tx_msg_len, .tx_msg_data);
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      errors = errors + 1;
      conclude();
    end
  end
  task automatic conclude();
    $display("Comparisons %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({63'h0, got}, {63'h0, exp});
  endtask
  function automatic logic [63:0] keep(input logic [63:0] d, input logic [3:0] len);
    keep = d;
    for (int i = len; i < 8; i++)
      keep[i*8 +: 8] = 8'h00;
  endfunction
  function automatic logic ext_of(input logic [1:0] fmt, input logic [ID_W-1:0] id);
    ext_of = (fmt == 2'd1) || (fmt[1] && id >= 29'd2047);
  endfunction
  function automatic logic [31:0] ctrl(input logic re, te, rs, ts, input logic [1:0] rf, tf,
    input logic tm, input logic [1:0] tt, input logic [2:0] l);
    ctrl = {16'h0, 1'b1, 1'b1, l, tt, tm, tf, rf, ts, rs, te, re};
  endfunction
  // Ready is sampled mid-cycle, where the design's comb ready has settled
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      aw_hs = s_axi_awvalid & s_axi_awready;
      w_hs = s_axi_wvalid & s_axi_wready;
      b_hs = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (aw_hs)
        s_axi_awvalid <= 1'b0;
      if (w_hs)
        s_axi_wvalid <= 1'b0;
    end
    while (b_hs !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    logic ar_hs, hs;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge sys_clk);
      ar_hs = s_axi_arvalid & s_axi_arready;
      hs = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ar_hs)
        s_axi_arvalid <= 1'b0;
    end
    while (hs !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    rd(a, d);
    chk_val(d, e);
    chk_val(r, er);
  endtask
  task automatic wait_tick();
    do
      @(negedge sys_clk);
    while (step_tick !== 1'b1);
  endtask
  task automatic rx_case(input logic [1:0] fmt, input logic src, input logic [ID_W-1:0] id);
    logic [3:0] len;
    logic [63:0] d;
    logic e;
    e = ext_of(fmt, id);
    len = 4'(1 + {$random(seed)} % 8);
    d = {$random(seed), $random(seed)};
    @(posedge sys_clk);
    rx_id_in <= src ? id : ~id;
    wr(OFF_RX_ID, 32'(src ? ~id : id));
    wr(OFF_CTRL, ctrl(1'b1, 1'b0, src, 1'b0, fmt, 2'd0, 1'b0, 2'd0, 3'd7));
    wr(OFF_IRQ_MASK, 32'h1);
    wait_tick();
    // Decoys first, so the last frame, the only match, is the one whose data is checked
    i_can_bus_node.send(1'b0, id, e, len, ~d);
    i_can_bus_node.send(1'b1, id ^ 29'h1, e, len, ~d);
    i_can_bus_node.send(1'b1, id, ~e, len, ~d);
    i_can_bus_node.send(1'b1, id, e, len, d);
    wait_tick();
    @(negedge sys_clk);
    chk_flag(rx_new, 1'b1);
    chk_val(rx_data, keep(d, len));
    chk_flag(irq, 1'b1);
    wr(OFF_IRQ_STAT, 32'h1);
    rd_chk(OFF_RX_HI, 32'(keep(d, len) >> 32), RESP_OKAY);
    rd_chk(OFF_RX_LO, 32'(keep(d, len)), RESP_OKAY);
    rd_chk(OFF_STATUS, 32'h1, RESP_OKAY);
    chk_flag(irq, 1'b0);
    wait_tick();
    @(negedge sys_clk);
    chk_flag(rx_new, 1'b0);
  endtask
  task automatic tx_reg(input logic src, input logic [1:0] fmt, input int per, input int st);
    logic [ID_W-1:0] id;
    logic [3:0] len;
    logic [63:0] d;
    logic [130:0] rec;
    logic [31:0] last;
    id = 29'($random(seed));
    len = 4'(1 + {$random(seed)} % 8);
    d = {$random(seed), $random(seed)};
    @(posedge sys_clk);
    tx_id_in <= src ? id : ~id;
    tx_data_in <= d;
    tx_trigger <= 8'($random(seed));
    i_can_bus_node.stall = st;
    wr(OFF_TX_ID, 32'(src ? ~id : id));
    wr(OFF_TX_PERIOD, 32'(per));
    wr(OFF_CTRL, ctrl(1'b0, 1'b1, 1'b0, src, 2'd0, fmt, 1'b0, 2'd0, 3'(len - 1)));
    i_can_bus_node.got_q.delete();
    repeat (6 * per) wait_tick();
    wr(OFF_CTRL, 32'h0);
    repeat (2) wait_tick();
    chk_flag(i_can_bus_node.got_q.size() inside {[5:7]}, 1'b1);
    for (int k = 0; k < i_can_bus_node.got_q.size(); k++)
    begin
      rec = i_can_bus_node.got_q[k];
      chk_val(rec[92:64], ext_of(fmt, id) ? id : id & 29'h7ff);
      chk_flag(rec[97], ext_of(fmt, id));
      chk_flag(rec[98], 1'b1);
      chk_val(rec[96:93], len);
      chk_val(rec[63:0], keep(d, len));
      if (k > 0)
        chk_val(rec[130:99] - last, 32'(per * 100));
      last = rec[130:99];
    end
  endtask
  task automatic tx_trig(input logic [1:0] tt);
    logic [7:0] prev, cur;
    int n;
    wr(OFF_CTRL, 32'h0);
    @(posedge sys_clk);
    tx_trigger <= 8'h00;
    wait_tick();
    wr(OFF_CTRL, ctrl(1'b0, 1'b1, 1'b0, 1'b0, 2'd0, 2'd0, 1'b1, tt, 3'd7));
    i_can_bus_node.got_q.delete();
    prev = 8'h00;
    n = 0;
    repeat (16)
    begin
      cur = ($random(seed) & 1) ? 8'($random(seed)) : 8'h00;
      @(posedge sys_clk);
      tx_trigger <= cur;
      wait_tick();
      if ((tt != 2'd1 && prev == 0 && cur != 0) || (tt != 2'd0 && prev != 0 && cur == 0))
        n++;
      prev = cur;
    end
    repeat (2) wait_tick();
    chk_val(i_can_bus_node.got_q.size(), n);
  endtask
  initial
  begin
    seed = 32'h600a43ea;
    errors = 0;
    tests_run = 0;
    cycles = 0;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {rx_id_in, tx_id_in, tx_data_in, tx_trigger} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(OFF_CTRL, 32'(CTRL_RST), RESP_OKAY);
    rd_chk(OFF_TX_PERIOD, 32'(PERIOD_RST), RESP_OKAY);
    rd_chk(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
    rd_chk(8'h24, 32'h0, RESP_SLVERR);
    wr(8'h24, 32'h0);
    chk_val(r, RESP_SLVERR);
    rx_case(2'd0, 1'b0, 29'({$random(seed)} % 2047));
    rx_case(2'd1, 1'b1, 29'($random(seed)));
    rx_case(2'd2, 1'b0, 29'd2046);
    rx_case(2'd3, 1'b1, 29'd2047);
    tx_reg(1'b0, 2'd1, 2, 0);
    tx_reg(1'b1, 2'd0, 1, 30);
    tx_reg(1'b0, 2'd2, 3, 5);
    for (int t = 0; t < 4; t++)
      tx_trig(2'(t));
    conclude();
  end
endmodule
